// file: design/i2c_engine_pkg.sv
// Purpose: shared constants, types and encodings of the serial command engine
// Assumes: pclk at 100 MHz, APB with 32-bit data
// Notes: command codes and register offsets are used by the engine and the bench
package i2c_engine_pkg;

  // ***************************************************
  // clocking and timing
  // ***************************************************
  localparam int unsigned PCLK_MHZ = 100;
  localparam int unsigned SRC_MHZ = 60; // internal bit clock source
  localparam int unsigned LATENCY_MS = 16;
  localparam int unsigned LATENCY_CYCLES = LATENCY_MS * PCLK_MHZ * 1000;
  localparam logic [15:0] DIVIDER_RST = 16'h0031;

  // ***************************************************
  // register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DIVIDER = 8'h0c;

  // ***************************************************
  // status and response field positions
  // ***************************************************
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_CMD_FULL_BIT = 1;
  localparam int unsigned ST_THREE_PH_BIT = 2;
  localparam int unsigned ST_ACK_BIT = 3;
  localparam int unsigned ST_PKT_BIT = 4;
  localparam int unsigned ST_AVAIL_LSB = 8;
  localparam int unsigned RESP_VALID_BIT = 8;

  // ***************************************************
  // command set
  // ***************************************************
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h11;
  localparam logic [7:0] CMD_READ_BIT = 8'h22;
  localparam logic [7:0] CMD_SET_LOW = 8'h80;
  localparam logic [7:0] CMD_SET_HIGH = 8'h82;
  localparam logic [7:0] CMD_SET_DIV = 8'h86;
  localparam logic [7:0] CMD_SEND_NOW = 8'h87;
  localparam logic [7:0] CMD_THREE_PH_ON = 8'h8c;
  localparam logic [7:0] CMD_THREE_PH_OFF = 8'h8d;
  localparam logic [7:0] CMD_DRIVE_ZERO = 8'h9e;
  localparam logic [7:0] ERR_MARKER = 8'hfa;

  // ***************************************************
  // pin layout of the low byte and reset values
  // ***************************************************
  localparam int unsigned SCL_BIT = 0;
  localparam int unsigned SDA_OUT_BIT = 1;
  localparam int unsigned SDA_IN_BIT = 2;
  localparam logic [15:0] PIN_VAL_RST = 16'h0000;
  localparam logic [15:0] PIN_DIR_RST = 16'h0000;
  localparam logic [15:0] PIN_OD_RST = 16'h0000;

  // pin drive settings travel together
  typedef struct packed {
    logic [7:0] high_pin_byte;
    logic [7:0] low_pin_byte;
  } pin_word_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_ARG1 = 3'b001,
    ENG_ARG2 = 3'b010,
    ENG_SHIFT = 3'b011,
    ENG_ERR2 = 3'b100
  } eng_state_t;

endpackage

// file: design/bit_clock_gen.sv
// Purpose: phase tick generator derived from a 60 MHz equivalent source
// Assumes: pclk at 100 MHz; run held high for a whole transfer
// Notes: each phase lasts (1 + divider) source periods
`timescale 1ns/1ns
module bit_clock_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [15:0] divider,
  // phase strobe
  output logic phase_tick
);

  logic [7:0] acc_ff;
  logic [15:0] cnt_ff;
  logic src_tick;
  logic [8:0] acc_sum;

  // fractional step turns 100 MHz into 60 MHz equivalent ticks
  assign acc_sum = {1'b0, acc_ff} + 9'(i2c_engine_pkg::SRC_MHZ);
  assign src_tick = run && (acc_sum >= 9'(i2c_engine_pkg::PCLK_MHZ));

  // accumulator restarts so every transfer has the same phase alignment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 8'h00;
    end else if (!run) begin
      acc_ff <= 8'h00;
    end else if (src_tick) begin
      acc_ff <= 8'(acc_sum - 9'(i2c_engine_pkg::PCLK_MHZ));
    end else begin
      acc_ff <= acc_sum[7:0];
    end
  end

  // count 1 + divider source ticks per phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (!run) begin
      cnt_ff <= 16'h0000;
    end else if (src_tick) begin
      cnt_ff <= (cnt_ff == divider) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  assign phase_tick = src_tick && (cnt_ff == divider);
endmodule

// file: design/latency_timer.sv
// Purpose: periodic packet timer toward the host
// Assumes: restart pulses come from the engine on every forced send
// Notes: the period is long; shorten it by parameter in simulation
`timescale 1ns/1ns
module latency_timer #(
  parameter int unsigned PERIOD = i2c_engine_pkg::LATENCY_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  // expiry strobe
  output logic expire
);

  logic [31:0] cnt_ff;

  assign expire = (cnt_ff == 32'(PERIOD - 1));

  // free-running count, restarted by send-immediate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h00000000;
    end else if (restart || expire) begin
      cnt_ff <= 32'h00000000;
    end else begin
      cnt_ff <= cnt_ff + 32'h00000001;
    end
  end
endmodule

// file: design/i2c_cmd_engine.sv
// Purpose: serial command engine acting as a two-wire bus master
// Assumes: APB slave, 100 MHz pclk, SDA out and SDA in tied outside
// Notes: responses become readable only after a send or timer expiry
`timescale 1ns/1ns
module i2c_cmd_engine #(
  parameter int unsigned LATENCY_PERIOD = i2c_engine_pkg::LATENCY_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);

  // ***************************************************
  // declarations
  // ***************************************************
  localparam int unsigned RESP_DEPTH = 4;

  i2c_engine_pkg::eng_state_t state_ff;
  i2c_engine_pkg::pin_word_t pin_val_ff;
  i2c_engine_pkg::pin_word_t pin_dir_ff;
  i2c_engine_pkg::pin_word_t pin_od_ff;
  logic [7:0] cmd_ff;
  logic cmd_full_ff;
  logic [7:0] op_ff;
  logic [7:0] arg1_ff;
  logic [15:0] divider_ff;
  logic three_ph_ff;
  logic [7:0] shreg_ff;
  logic [2:0] bit_cnt_ff;
  logic [1:0] phase_ff;
  logic is_read_ff;
  logic ack_ff;
  logic pkt_ff;
  logic [7:0] resp_mem [RESP_DEPTH];
  logic [2:0] wr_ptr_ff;
  logic [2:0] rd_ptr_ff;
  logic [2:0] rel_ptr_ff;
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  logic [15:0] sync3_ff;
  logic [15:0] pin_stable_ff;
  logic setup_ok;
  logic wr_cmd;
  logic rd_resp;
  logic rd_status;
  logic wr_div;
  logic take_cmd;
  logic push_en;
  logic [7:0] push_data;
  logic flush;
  logic expire;
  logic phase_tick;
  logic running;
  logic last_phase;
  logic scl_drv;
  logic sda_drv;
  logic [2:0] used;
  logic [2:0] avail;
  logic resp_has_room;
  logic needs_room;
  logic [15:0] eff_val;

  // ***************************************************
  // helpers
  // ***************************************************
  // a command known to the engine
  function automatic logic known_cmd(input logic [7:0] c);
    case (c)
      i2c_engine_pkg::CMD_WRITE_BYTE, i2c_engine_pkg::CMD_READ_BIT,
      i2c_engine_pkg::CMD_SET_LOW, i2c_engine_pkg::CMD_SET_HIGH,
      i2c_engine_pkg::CMD_SET_DIV, i2c_engine_pkg::CMD_SEND_NOW,
      i2c_engine_pkg::CMD_THREE_PH_ON, i2c_engine_pkg::CMD_THREE_PH_OFF,
      i2c_engine_pkg::CMD_DRIVE_ZERO: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  endfunction

  // commands carrying two argument bytes
  function automatic logic two_args(input logic [7:0] c);
    two_args = (c == i2c_engine_pkg::CMD_SET_LOW) || (c == i2c_engine_pkg::CMD_SET_HIGH) ||
               (c == i2c_engine_pkg::CMD_SET_DIV) || (c == i2c_engine_pkg::CMD_DRIVE_ZERO);
  endfunction

  // ***************************************************
  // apb decode
  // ***************************************************
  assign setup_ok = psel && penable;
  assign wr_cmd = setup_ok && pwrite && (paddr == i2c_engine_pkg::OFS_CMD);
  assign wr_div = setup_ok && pwrite && (paddr == i2c_engine_pkg::OFS_DIVIDER) && pready;
  assign rd_resp = setup_ok && !pwrite && (paddr == i2c_engine_pkg::OFS_RESP);
  assign rd_status = setup_ok && !pwrite && (paddr == i2c_engine_pkg::OFS_STATUS);
  // back-pressure: a command write waits while the previous byte is unparsed
  assign pready = !(wr_cmd && cmd_full_ff);
  assign pslverr = setup_ok && (paddr != i2c_engine_pkg::OFS_CMD) &&
                   (paddr != i2c_engine_pkg::OFS_RESP) &&
                   (paddr != i2c_engine_pkg::OFS_STATUS) &&
                   (paddr != i2c_engine_pkg::OFS_DIVIDER);

  assign used = wr_ptr_ff - rd_ptr_ff;
  assign avail = rel_ptr_ff - rd_ptr_ff;
  // two free slots needed so an error echo never splits
  assign resp_has_room = (used <= 3'(RESP_DEPTH - 2));

  // read data mux
  always_comb begin
    prdata = 32'h00000000;
    if (rd_resp && (avail != 3'h0)) begin
      prdata[7:0] = resp_mem[rd_ptr_ff[1:0]];
      prdata[i2c_engine_pkg::RESP_VALID_BIT] = 1'b1;
    end else if (rd_status) begin
      prdata[i2c_engine_pkg::ST_BUSY_BIT] = (state_ff != i2c_engine_pkg::ENG_IDLE);
      prdata[i2c_engine_pkg::ST_CMD_FULL_BIT] = cmd_full_ff;
      prdata[i2c_engine_pkg::ST_THREE_PH_BIT] = three_ph_ff;
      prdata[i2c_engine_pkg::ST_ACK_BIT] = ack_ff;
      prdata[i2c_engine_pkg::ST_PKT_BIT] = pkt_ff;
      prdata[i2c_engine_pkg::ST_AVAIL_LSB +: 3] = avail;
    end else if (setup_ok && !pwrite && (paddr == i2c_engine_pkg::OFS_DIVIDER)) begin
      prdata[15:0] = divider_ff;
    end
  end
  // ***************************************************
  // command holding byte
  // ***************************************************
  // one byte at a time keeps the stream in written order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= 8'h00;
      cmd_full_ff <= 1'b0;
    end else if (wr_cmd && !cmd_full_ff) begin
      cmd_ff <= pwdata[7:0];
      cmd_full_ff <= 1'b1;
    end else if (take_cmd) begin
      cmd_full_ff <= 1'b0;
    end
  end

  // parse only when idle or awaiting arguments; only answering commands need room,
  // otherwise a full store would block the very send that empties it
  assign needs_room = (state_ff == i2c_engine_pkg::ENG_IDLE) &&
                      (!known_cmd(cmd_ff) || (cmd_ff == i2c_engine_pkg::CMD_READ_BIT));
  assign take_cmd = cmd_full_ff && (resp_has_room || !needs_room) &&
                    ((state_ff == i2c_engine_pkg::ENG_IDLE) ||
                     (state_ff == i2c_engine_pkg::ENG_ARG1) ||
                     (state_ff == i2c_engine_pkg::ENG_ARG2));

  // ***************************************************
  // input synchronisers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
      sync3_ff <= 16'h0000;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a pin changes once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stable_ff <= 16'h0000;
    end else begin
      pin_stable_ff <= (sync2_ff & sync3_ff) | (pin_stable_ff & (sync2_ff | sync3_ff));
    end
  end

  // ***************************************************
  // bit clock
  // ***************************************************
  assign running = (state_ff == i2c_engine_pkg::ENG_SHIFT);

  bit_clock_gen u_bit_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .divider(divider_ff),
    .phase_tick(phase_tick)
  );

  // three phases per bit instead of two stretch each bit by half
  assign last_phase = three_ph_ff ? (phase_ff == 2'd2) : (phase_ff == 2'd1);
  // clock high only in the middle phase: 1/3 duty in three-phase mode
  assign scl_drv = running && (phase_ff == 2'd1);
  // data set at bit start, stable over the rising edge; only three-phase mode also holds it over the falling edge
  assign sda_drv = is_read_ff ? 1'b1 : shreg_ff[7];

  // ***************************************************
  // engine state machine
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= i2c_engine_pkg::ENG_IDLE;
      op_ff <= 8'h00;
      arg1_ff <= 8'h00;
    end else begin
      case (state_ff)
        i2c_engine_pkg::ENG_IDLE: begin
          if (take_cmd) begin
            op_ff <= cmd_ff;
            if (!known_cmd(cmd_ff)) begin
              state_ff <= i2c_engine_pkg::ENG_ERR2;
            end else if (cmd_ff == i2c_engine_pkg::CMD_WRITE_BYTE || two_args(cmd_ff)) begin
              state_ff <= i2c_engine_pkg::ENG_ARG1;
            end else if (cmd_ff == i2c_engine_pkg::CMD_READ_BIT) begin
              state_ff <= i2c_engine_pkg::ENG_SHIFT;
            end
          end
        end
        i2c_engine_pkg::ENG_ARG1: begin
          if (take_cmd) begin
            arg1_ff <= cmd_ff;
            if (op_ff == i2c_engine_pkg::CMD_WRITE_BYTE) begin
              state_ff <= i2c_engine_pkg::ENG_SHIFT;
            end else begin
              state_ff <= i2c_engine_pkg::ENG_ARG2;
            end
          end
        end
        i2c_engine_pkg::ENG_ARG2: begin
          if (take_cmd) begin
            state_ff <= i2c_engine_pkg::ENG_IDLE;
          end
        end
        i2c_engine_pkg::ENG_SHIFT: begin
          if (phase_tick && last_phase && (is_read_ff || bit_cnt_ff == 3'd7)) begin
            state_ff <= i2c_engine_pkg::ENG_IDLE;
          end
        end
        i2c_engine_pkg::ENG_ERR2: begin
          state_ff <= i2c_engine_pkg::ENG_IDLE;
        end
        default: begin
          state_ff <= i2c_engine_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // ***************************************************
  // shifter
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_ff <= 8'hff;
      bit_cnt_ff <= 3'd0;
      phase_ff <= 2'd0;
      is_read_ff <= 1'b0;
    end else if (state_ff == i2c_engine_pkg::ENG_IDLE && take_cmd &&
                 cmd_ff == i2c_engine_pkg::CMD_READ_BIT) begin
      is_read_ff <= 1'b1;
      bit_cnt_ff <= 3'd0;
      phase_ff <= 2'd0;
    end else if (state_ff == i2c_engine_pkg::ENG_ARG1 && take_cmd &&
                 op_ff == i2c_engine_pkg::CMD_WRITE_BYTE) begin
      shreg_ff <= cmd_ff;
      is_read_ff <= 1'b0;
      bit_cnt_ff <= 3'd0;
      phase_ff <= 2'd0;
    end else if (running && phase_tick) begin
      if (last_phase) begin
        phase_ff <= 2'd0;
        bit_cnt_ff <= bit_cnt_ff + 3'd1;
        shreg_ff <= {shreg_ff[6:0], 1'b1}; // MSB first
      end else begin
        phase_ff <= phase_ff + 2'd1;
      end
    end
  end

  // acknowledge sampled as the clock falls after its high phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b1;
    end else if (running && is_read_ff && phase_tick && phase_ff == 2'd1) begin
      ack_ff <= pin_stable_ff[i2c_engine_pkg::SDA_IN_BIT];
    end
  end

  // ***************************************************
  // configuration held by commands
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_val_ff <= i2c_engine_pkg::PIN_VAL_RST;
      pin_dir_ff <= i2c_engine_pkg::PIN_DIR_RST;
      pin_od_ff <= i2c_engine_pkg::PIN_OD_RST;
      divider_ff <= i2c_engine_pkg::DIVIDER_RST;
      three_ph_ff <= 1'b0;
    end else if (wr_div) begin
      divider_ff <= pwdata[15:0];
    end else if (state_ff == i2c_engine_pkg::ENG_IDLE && take_cmd) begin
      if (cmd_ff == i2c_engine_pkg::CMD_THREE_PH_ON) begin
        three_ph_ff <= 1'b1;
      end else if (cmd_ff == i2c_engine_pkg::CMD_THREE_PH_OFF) begin
        three_ph_ff <= 1'b0;
      end
    end else if (state_ff == i2c_engine_pkg::ENG_ARG2 && take_cmd) begin
      case (op_ff)
        i2c_engine_pkg::CMD_SET_LOW: begin
          pin_val_ff.low_pin_byte <= arg1_ff;
          pin_dir_ff.low_pin_byte <= cmd_ff;
        end
        i2c_engine_pkg::CMD_SET_HIGH: begin
          pin_val_ff.high_pin_byte <= arg1_ff;
          pin_dir_ff.high_pin_byte <= cmd_ff;
        end
        i2c_engine_pkg::CMD_SET_DIV: begin
          divider_ff <= {cmd_ff, arg1_ff};
        end
        i2c_engine_pkg::CMD_DRIVE_ZERO: begin
          pin_od_ff <= {cmd_ff, arg1_ff};
        end
        default: begin
          divider_ff <= divider_ff;
        end
      endcase
    end
  end

  // ***************************************************
  // pin drive
  // ***************************************************
  // the engine owns clock and data only while shifting
  always_comb begin
    eff_val = pin_val_ff;
    if (running) begin
      eff_val[i2c_engine_pkg::SCL_BIT] = scl_drv;
      eff_val[i2c_engine_pkg::SDA_OUT_BIT] = sda_drv;
    end
  end

  // drive-only-zero pins never push a one; the pull-up makes it
  assign pin_out = eff_val & ~pin_od_ff;
  assign pin_oe = pin_dir_ff & ~(pin_od_ff & eff_val);

  // ***************************************************
  // response store
  // ***************************************************
  always_comb begin
    push_en = 1'b0;
    push_data = 8'h00;
    if (state_ff == i2c_engine_pkg::ENG_IDLE && take_cmd && !known_cmd(cmd_ff)) begin
      push_en = 1'b1;
      push_data = i2c_engine_pkg::ERR_MARKER;
    end else if (state_ff == i2c_engine_pkg::ENG_ERR2) begin
      push_en = 1'b1;
      push_data = op_ff;
    end else if (running && is_read_ff && phase_tick && last_phase) begin
      push_en = 1'b1;
      // ack bit in the lsb of one byte; two-phase pushes in the sampling cycle
      push_data = {7'h00, ack_ff};
      if (phase_ff == 2'd1) begin
        push_data[0] = pin_stable_ff[i2c_engine_pkg::SDA_IN_BIT];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (push_en) begin
      resp_mem[wr_ptr_ff[1:0]] <= push_data;
    end
  end

  assign flush = (state_ff == i2c_engine_pkg::ENG_IDLE) && take_cmd &&
                 (cmd_ff == i2c_engine_pkg::CMD_SEND_NOW);

  latency_timer #(
    .PERIOD(LATENCY_PERIOD)
  ) u_latency_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(flush),
    .expire(expire)
  );

  // pointers: bytes below the release pointer are visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= 3'd0;
      rd_ptr_ff <= 3'd0;
      rel_ptr_ff <= 3'd0;
    end else begin
      if (push_en) begin
        wr_ptr_ff <= wr_ptr_ff + 3'd1;
      end
      if (rd_resp && (avail != 3'h0)) begin
        rd_ptr_ff <= rd_ptr_ff + 3'd1;
      end
      if (flush) begin
        rel_ptr_ff <= wr_ptr_ff;
      end else if (expire) begin
        rel_ptr_ff <= wr_ptr_ff;
      end
    end
  end

  // packet flag: timer sends even when empty; a new send beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ff <= 1'b0;
    end else if (expire || flush) begin
      pkt_ff <= 1'b1;
    end else if (rd_status) begin
      pkt_ff <= 1'b0;
    end
  end
endmodule

// file: dv/i2c_cmd_engine_chk.sv
// Purpose: port checks of the serial command engine
// Assumes: one clock domain, async active-low reset
// Notes: released pins are read as high, as through pull-ups
`timescale 1ns/1ns
module i2c_cmd_engine_chk #(
  parameter int unsigned LATENCY_PERIOD = i2c_engine_pkg::LATENCY_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  // ****
  // helpers and checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // map covers the four aligned words only
  wire logic acc = psel && penable;
  wire logic map = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  wire logic rd = acc && !pwrite && paddr == i2c_engine_pkg::OFS_RESP;
  wire logic scl = pin_oe[0] ? pin_out[0] : 1'b1;
  wire logic sda = pin_oe[1] ? pin_out[1] : 1'b1;
  unmapped_err_a: assert property (acc && !map |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  stall_cmd_a: assert property (!pready |-> acc && pwrite && paddr == 8'h00)
    else $error("wait state outside a command write");
  stall_bound_a: assert property ($fell(pready) |-> ##[1:1000] pready)
    else $error("command write stalled too long");
  resp_empty_a: assert property (rd && !prdata[8] |-> prdata == 32'h0)
    else $error("empty response read not zero");
  resp_width_a: assert property (rd |-> prdata[31:9] == 23'h0)
    else $error("response wider than one byte");
  scl_rise_a: assert property ($rose(scl) |-> $stable(sda))
    else $error("data moved at clock rise");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(sda))
    else $error("data moved while clock high");
  cover property (!pready);
  cover property (rd && prdata[8]);
  cover property ($rose(scl));
endmodule
bind i2c_cmd_engine i2c_cmd_engine_chk #(.LATENCY_PERIOD(LATENCY_PERIOD)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .pin_oe(pin_oe));

// file: dv/i2c_slave_model.sv
// Purpose: acknowledging slave on the two-wire bus
// Assumes: nine clock rises per byte, the ninth is the acknowledge
// Notes: only ever pulls low; high comes from the pull-up
`timescale 1ns/1ns
module i2c_slave_model (
  // reset and bus clock level
  input wire logic presetn,
  input wire logic scl,
  // acknowledge choice and data pull-down
  input wire logic ack_en,
  output logic pull
);
  // ****
  // bit counting and acknowledge
  // ****
  int n;
  // reset also swallows the unknown-to-high edge at start
  always @(posedge scl or negedge presetn) begin
    if (!presetn) n <= 0;
    else n <= (n == 8) ? 0 : n + 1;
  end
  // pull in the slot after the eighth rise, release after it
  always @(negedge scl or negedge presetn) begin
    if (!presetn) pull <= 1'b0;
    else pull <= ack_en && n == 8;
  end
endmodule

// file: dv/i2c_cmd_engine_test.sv
// Purpose: self-checking bench of the serial command engine
// Assumes: divider 2 gives exactly five pclk cycles per phase
// Notes: random data byte and acknowledge per pass; random upper bits of the low pin byte drawn once before both passes
`timescale 1ns/1ns
module i2c_cmd_engine_test;
  // ****
  // signals, clock, design and slave
  // ****
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_en = 0;
  logic [7:0] paddr = 8'h00, b, v;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, pull, sda, scl_q = 1;
  logic [15:0] pin_out, pin_oe, lvl;
  logic [8:0] bits = 9'h0;
  int cnt = 0, hi = 0, per = 0, hlen = 0, n_mismatch = 0, samples_checked = 0;
  int seed = 52430;
  initial begin
    forever #5 pclk = ~pclk;
  end
  // pull-ups on all released lines
  assign lvl = (pin_oe & pin_out) | ~pin_oe;
  assign sda = lvl[1] & ~pull;
  i2c_cmd_engine #(.LATENCY_PERIOD(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in({lvl[15:3], sda, sda, lvl[0]}),
    .pin_out(pin_out), .pin_oe(pin_oe));
  i2c_slave_model slave (.presetn(presetn), .scl(lvl[0]), .ack_en(ack_en), .pull(pull));
  // bus monitor: period, high time, bits at each rise
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    hi <= lvl[0] ? hi + 1 : 0;
    scl_q <= lvl[0];
    if (lvl[0] && !scl_q) begin
      per <= cnt;
      cnt <= 1;
      bits <= {bits[7:0], sda};
    end
    if (!lvl[0] && scl_q) hlen <= hi;
  end
  // ****
  // tasks
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, 8'h00, {24'h0, c});
  endtask
  task automatic st;
    apb(1'b0, i2c_engine_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pop(input string n, input logic [7:0] e);
    apb(1'b0, i2c_engine_pkg::OFS_RESP, 32'h0);
    chk(n, {23'h0, 1'b1, e}, rdata);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, i2c_engine_pkg::OFS_DIVIDER, 32'h2);
    apb(1'b0, i2c_engine_pkg::OFS_DIVIDER, 32'h0);
    chk("divider", 32'h2, rdata);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    $display("test registers done");
    // unknown opcodes answer in order, only once sent
    cmd(8'haa);
    cmd(8'hab);
    st();
    chk("held", 32'h0, {29'h0, rdata[10:8]});
    cmd(i2c_engine_pkg::CMD_SEND_NOW);
    st();
    chk("count", 32'h4, {29'h0, rdata[10:8]});
    pop("marker", i2c_engine_pkg::ERR_MARKER);
    pop("opcode", 8'haa);
    pop("marker", i2c_engine_pkg::ERR_MARKER);
    pop("opcode", 8'hab);
    $display("test bad opcodes done");
    // drive-only-zero on the bus lines and one high pin; bit 7 stays an input
    v = (8'($random(seed)) & 8'hf8) | 8'h02;
    cmd(i2c_engine_pkg::CMD_DRIVE_ZERO);
    cmd(8'h07);
    cmd(8'h01);
    cmd(i2c_engine_pkg::CMD_SET_LOW);
    cmd(v);
    cmd(8'h7b);
    cmd(i2c_engine_pkg::CMD_SET_HIGH);
    cmd(8'h03);
    cmd(8'h03);
    st();
    chk("low oe", 32'h79, {24'h0, pin_oe[7:0]});
    chk("low out", {25'h0, v[6:3], 3'h0}, {25'h0, pin_out[6:0]});
    chk("high", 32'h6, {29'h0, pin_out[9], pin_oe[9:8]});
    $display("test pins done");
    for (int m = 0; m < 2; m++) begin
      b = 8'($random(seed));
      ack_en <= 1'($random(seed));
      cmd(m ? i2c_engine_pkg::CMD_THREE_PH_ON : i2c_engine_pkg::CMD_THREE_PH_OFF);
      cmd(i2c_engine_pkg::CMD_WRITE_BYTE);
      cmd(b);
      cmd(i2c_engine_pkg::CMD_SET_LOW);
      cmd(v);
      cmd(8'h7b);
      chk("period", m ? 32'd15 : 32'd10, per);
      chk("high time", 32'd5, hlen);
      cmd(i2c_engine_pkg::CMD_READ_BIT);
      cmd(i2c_engine_pkg::CMD_SEND_NOW);
      st();
      while (rdata[i2c_engine_pkg::ST_CMD_FULL_BIT] || rdata[i2c_engine_pkg::ST_BUSY_BIT]) st();
      chk("ack count", 32'h1, {29'h0, rdata[10:8]});
      chk("ack flag", {31'h0, ~ack_en}, {31'h0, rdata[i2c_engine_pkg::ST_ACK_BIT]});
      pop("ack", {7'h0, ~ack_en});
      chk("bits", {23'h0, b, ~ack_en}, {23'h0, bits});
      $display("test byte pass %0d done", m);
    end
    // idle packet on timer expiry, flag clears on read
    repeat (250) @(posedge pclk);
    st();
    chk("packet", 32'h1, {31'h0, rdata[4]});
    st();
    chk("packet clr", 32'h0, {31'h0, rdata[4]});
    $display("test timer done");
    end_sim();
  end
endmodule
